// ===== rtl/sbc_supervisor.sv
// Protection and reset supervisor: modes, sleep/wake timer, resets, dominant timeout, thermal
//
// How it works
// - Divider output on only with enable high in normal, fail-safe, fast, standby.
// - Pin control starts sleep/wake timer on entering fail-safe or restart.
// - Wake in sleep goes restart; supply still low at timeout returns sleep.
// - Serial control starts enabled timer on entering fail-safe, restart or standby.
// - Host must transact in standby before timeout, else fail-safe or sleep.
// - Configuration bit 7 set disables the sleep/wake timer.
// - Bits 6 to 3 select timeout, 30 s to 10 min, default 5 min.
// - Reset command 02h is soft reset, 01h is hard reset.
// - Host holding reset pin low long enough then releasing resets device.
// - Soft reset: restart, pin low for toggle time, standby, defaults restored.
// - Soft reset clears flags unless fault persists; power-on flag kept.
// - Hard reset acts as power-up: init, regulator on, straps resampled.
// - Pin reset: restart, pin low toggle time, standby, registers and flags kept.
// - Transmit low beyond dominant timeout in normal disables transmitter.
// - Rising transmit edge clears timeout; mode and receive path unchanged.
// - Transceiver configuration bit 5 set disables the dominant timeout.
// - Bus dominant on sleep entry locks bus wake until recessive seen.
// - Transceiver or regulator overheating: transmitter off, regulator off, reset low.
// - Switch overheating turns the switch off until temperature releases.
// - Pin control overheating enters fail-safe; wake leads restart or sleep.
// - Serial control sets separate flags for the two thermal event kinds.
// - Serial overheating enters fail-safe with limp on, or sleep if disabled.
// - Fail-safe configuration bit 0 bypasses fail-safe; pin control always uses it.
module sbc_supervisor import sbc_pkg::*; #(
   parameter int unsigned RST_IN_CYC_P = RESET_INPUT_PULSE_CYC,
   parameter int unsigned TOG_CYC_P = RESET_TOGGLE_CYC,
   parameter int unsigned DTO_CYC_P = DOMINANT_TIMEOUT_CYC,
   parameter int unsigned MS_CYC_P = MS_CYC
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire sbc_pins_t pins_i,
   input wire logic spi_normal_req_i,
   input wire logic spi_fast_req_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic spi_txn_i,
   output logic [7:0] reg_rdata_o,
   output logic battery_sense_out_o,
   output logic reset_pin_bidir_o,
   output logic reset_pin_bidir_oe_o,
   output logic inhibit_out_o,
   output logic wake_request_out_o,
   output logic tx_enable_o,
   output logic regulator_en_o,
   output logic high_side_switch_off_o,
   output logic limp_on_o,
   output logic wake_lockout_o,
   output sbc_mode_t mode_o,
   output logic [2:0] flags_o
);
   logic rst_meta_q;
   logic rst_n;
   sbc_pins_t pin_s;
   sbc_pins_t pin_prev_q;
   sbc_mode_t mode_q;
   sbc_mode_t mode_d;
   logic spi_q;
   logic wake_request_out_q;
   logic [7:0] swt_cfg_q;
   logic [7:0] xcvr_cfg_q;
   logic [7:0] fs_cfg_q;
   logic [2:0] flags_q;
   logic rst_tog_q;
   logic swe_run_q;
   logic dto_run_q;
   logic lockout_q;
   logic soft_req;
   logic hard_req;
   logic pin_rst;
   logic fs_on;
   logic wr_ok;
   logic tsd_rise;
   logic wake_any;
   logic go_normal;
   logic mode_change;
   logic swe_entry;
   logic swe_exp;
   logic swe_done;
   logic ms_tick;
   logic tog_done;
   logic rst_in_done;
   logic dto_done;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   sbc_sync #(.W($bits(sbc_pins_t)), .INIT(PINS_RST)) u_pin_sync (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .d_i(pins_i),
      .q_o(pin_s)
   );

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_q <= PINS_RST;
      end else begin
         pin_prev_q <= pin_s;
      end
   end

   // Straps follow the pins while in init and freeze on leaving it
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         spi_q <= 1'b0;
         wake_request_out_q <= 1'b0;
      end else if (mode_q == M_INIT) begin
         spi_q <= pin_s.spi_sel;
         wake_request_out_q <= pin_s.wake_request_out_sel;
      end
   end

   assign wr_ok = reg_wr_i && spi_q;
   assign soft_req = wr_ok && (reg_addr_i == ADDR_RESET_CMD) && (reg_wdata_i == CMD_SOFT_RESET);
   assign hard_req = wr_ok && (reg_addr_i == ADDR_RESET_CMD) && (reg_wdata_i == CMD_HARD_RESET);
   assign fs_on = !spi_q || !fs_cfg_q[FAILSAFE_DISABLE_BIT_BIT];
   assign tsd_rise = pin_s.tsd_xr && !pin_prev_q.tsd_xr;
   assign wake_any = (pin_s.wake && !pin_prev_q.wake) || (!pin_s.lin_rx && !lockout_q);
   assign go_normal = spi_q ? spi_normal_req_i : pin_s.en;

   // Configuration registers; soft and hard resets restore defaults
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         swt_cfg_q <= SWT_CFG_RST;
         xcvr_cfg_q <= XCVR_CFG_RST;
         fs_cfg_q <= FAILSAFE_CFG_RST;
      end else if (soft_req || hard_req) begin
         swt_cfg_q <= SWT_CFG_RST;
         xcvr_cfg_q <= XCVR_CFG_RST;
         fs_cfg_q <= FAILSAFE_CFG_RST;
      end else if (wr_ok) begin
         if (reg_addr_i == ADDR_SWT_CFG) begin
            swt_cfg_q <= reg_wdata_i;
         end
         if (reg_addr_i == ADDR_XCVR_CFG) begin
            xcvr_cfg_q <= reg_wdata_i;
         end
         if (reg_addr_i == ADDR_FAILSAFE_CFG) begin
            fs_cfg_q <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_SWT_CFG: reg_rdata_o <= swt_cfg_q;
            ADDR_XCVR_CFG: reg_rdata_o <= xcvr_cfg_q;
            ADDR_FAILSAFE_CFG: reg_rdata_o <= fs_cfg_q;
            ADDR_INT_FLAGS: reg_rdata_o <= {5'h00, flags_q};
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // Interrupt flags: set wins over a write-one-to-clear
   always_comb begin
      flag_set = 3'h0;
      flag_set[FLAG_POWER_ON] = hard_req;
      flag_set[FLAG_THERM_XR] = spi_q && tsd_rise;
      flag_set[FLAG_THERM_SW] = spi_q && pin_s.tsd_sw && !pin_prev_q.tsd_sw;
      flag_clr = 3'h0;
      if (wr_ok && (reg_addr_i == ADDR_INT_FLAGS)) begin
         flag_clr = reg_wdata_i[2:0];
      end
      if (soft_req) begin
         flag_clr[FLAG_THERM_XR] = !pin_s.tsd_xr;
         flag_clr[FLAG_THERM_SW] = !pin_s.tsd_sw;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // Reset pin held low by the host for at least the pulse time
   sbc_timer #(.W(24)) u_rst_in (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .clr_i(pin_s.rst_pin),
      .run_i(!pin_s.rst_pin && !reset_pin_bidir_oe_o),
      .limit_i(24'(RST_IN_CYC_P)),
      .done_o(rst_in_done)
   );
   assign pin_rst = pin_s.rst_pin && !pin_prev_q.rst_pin && rst_in_done && !reset_pin_bidir_oe_o;

   // Reset toggle time while a reset-caused restart drives the pin low
   sbc_timer #(.W(24)) u_tog (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .clr_i(!(mode_q == M_RESTART && rst_tog_q)),
      .run_i(1'b1),
      .limit_i(24'(TOG_CYC_P)),
      .done_o(tog_done)
   );

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rst_tog_q <= 1'b0;
      end else if (soft_req || pin_rst) begin
         rst_tog_q <= 1'b1;
      end else if (mode_q != M_RESTART || mode_d != M_RESTART) begin
         rst_tog_q <= 1'b0;
      end
   end

   // Millisecond tick and sleep/wake error timer
   sbc_timer #(.W(24)) u_ms (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .clr_i(ms_tick),
      .run_i(1'b1),
      .limit_i(24'(MS_CYC_P - 1)),
      .done_o(ms_tick)
   );

   assign mode_change = (mode_d != mode_q);
   assign swe_entry = mode_change && ((mode_d == M_FAILSAFE) || (mode_d == M_RESTART) ||
                      (spi_q && mode_d == M_STANDBY));

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         swe_run_q <= 1'b0;
      end else if (swe_entry) begin
         swe_run_q <= !(spi_q && swt_cfg_q[SWT_DIS_BIT]);
      end else if (mode_change || (spi_q && swt_cfg_q[SWT_DIS_BIT])) begin
         swe_run_q <= 1'b0;
      end else if (spi_txn_i && mode_q == M_STANDBY) begin
         swe_run_q <= 1'b0;
      end
   end

   sbc_timer #(.W(20)) u_swe (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .clr_i(swe_entry || !swe_run_q),
      .run_i(ms_tick),
      .limit_i(swe_ms(swt_cfg_q[SWT_SEL_MSB:SWT_SEL_LSB])),
      .done_o(swe_done)
   );
   assign swe_exp = swe_run_q && swe_done;

   // Operating mode
   always_comb begin
      mode_d = mode_q;
      if (hard_req) begin
         mode_d = M_INIT;
      end else if (tsd_rise && mode_q != M_SLEEP) begin
         mode_d = fs_on ? M_FAILSAFE : M_SLEEP;
      end else if (soft_req || pin_rst) begin
         mode_d = M_RESTART;
      end else begin
         unique case (mode_q)
            M_INIT: begin
               if (!pin_s.vcc_uv) begin
                  mode_d = M_STANDBY;
               end
            end
            M_NORMAL, M_FAST: begin
               if (!go_normal) begin
                  mode_d = M_STANDBY;
               end else begin
                  mode_d = (spi_q && spi_fast_req_i) ? M_FAST : M_NORMAL;
               end
            end
            M_STANDBY: begin
               if (swe_exp) begin
                  mode_d = fs_on ? M_FAILSAFE : M_SLEEP;
               end else if (go_normal) begin
                  mode_d = (spi_q && spi_fast_req_i) ? M_FAST : M_NORMAL;
               end
            end
            M_FAILSAFE: begin
               if (swe_exp) begin
                  mode_d = M_SLEEP;
               end else if (wake_any) begin
                  mode_d = (pin_s.tsd_xr || pin_s.vcc_uv) ? M_SLEEP : M_RESTART;
               end
            end
            M_SLEEP: begin
               if (wake_any) begin
                  mode_d = M_RESTART;
               end
            end
            M_RESTART: begin
               if (rst_tog_q) begin
                  if (tog_done) begin
                     mode_d = M_STANDBY;
                  end
               end else if (!pin_s.vcc_uv) begin
                  mode_d = M_STANDBY;
               end else if (swe_exp) begin
                  mode_d = M_SLEEP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= M_INIT;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Bus stuck dominant lockout sampled on sleep entry
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lockout_q <= 1'b0;
      end else if (mode_change && mode_d == M_SLEEP) begin
         lockout_q <= !pin_s.lin_rx;
      end else if (pin_s.lin_rx) begin
         lockout_q <= 1'b0;
      end
   end

   // Transmit dominant timeout, started by a falling edge in normal or fast
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         dto_run_q <= 1'b0;
      end else if (pin_s.txd || xcvr_cfg_q[DTO_DIS_BIT] || (mode_q != M_NORMAL && mode_q != M_FAST)) begin
         dto_run_q <= 1'b0;
      end else if (pin_prev_q.txd) begin
         dto_run_q <= 1'b1;
      end
   end

   sbc_timer #(.W(24)) u_dto (
      .clk_i(mclk_i),
      .rst_ni(rst_n),
      .clr_i(!dto_run_q),
      .run_i(1'b1),
      .limit_i(24'(DTO_CYC_P)),
      .done_o(dto_done)
   );

   // Output stage
   assign reset_pin_bidir_o = 1'b0;
   assign mode_o = mode_q;
   assign flags_o = flags_q;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         battery_sense_out_o <= 1'b0;
         reset_pin_bidir_oe_o <= 1'b1;
         tx_enable_o <= 1'b0;
         high_side_switch_off_o <= 1'b0;
         limp_on_o <= 1'b0;
         inhibit_out_o <= 1'b0;
         wake_request_out_o <= 1'b0;
         wake_lockout_o <= 1'b0;
      end else begin
         battery_sense_out_o <= pin_s.div_on && (mode_q == M_NORMAL || mode_q == M_FAILSAFE ||
                                                  mode_q == M_FAST || mode_q == M_STANDBY);
         reset_pin_bidir_oe_o <= (mode_q == M_RESTART) || pin_s.tsd_xr;
         tx_enable_o <= (mode_q == M_NORMAL || mode_q == M_FAST) &&
                        !(dto_run_q && dto_done) && !pin_s.tsd_xr;
         high_side_switch_off_o <= pin_s.tsd_sw;
         limp_on_o <= (mode_q == M_FAILSAFE);
         inhibit_out_o <= !wake_request_out_q && (mode_q != M_SLEEP) && (mode_q != M_INIT);
         wake_request_out_o <= wake_request_out_q && regulator_en_o && (mode_q != M_SLEEP) && (mode_q != M_INIT);
         wake_lockout_o <= lockout_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         regulator_en_o <= 1'b1;
      end else if (pin_s.tsd_xr) begin
         regulator_en_o <= 1'b0;
      end else if (mode_q == M_INIT || (mode_change && mode_d == M_RESTART && !rst_tog_q &&
                                         !soft_req && !pin_rst)) begin
         regulator_en_o <= 1'b1;
      end
   end
endmodule // sbc_supervisor

// ===== shared/sbc_pkg.sv
// Constants, types and timing for the protection and reset supervisor
package sbc_pkg;

   typedef enum logic [6:0] {
      M_INIT     = 7'h01,
      M_NORMAL   = 7'h02,
      M_FAST     = 7'h04,
      M_STANDBY  = 7'h08,
      M_FAILSAFE = 7'h10,
      M_SLEEP    = 7'h20,
      M_RESTART  = 7'h40
   } sbc_mode_t;

   typedef struct packed {
      logic div_on;
      logic txd;
      logic lin_rx;
      logic wake;
      logic en;
      logic vcc_uv;
      logic tsd_xr;
      logic tsd_sw;
      logic rst_pin;
      logic spi_sel;
      logic wake_request_out_sel;
   } sbc_pins_t;

   localparam sbc_pins_t PINS_RST = '{div_on: 1'b0, txd: 1'b1, lin_rx: 1'b1, wake: 1'b0, en: 1'b0,
                                      vcc_uv: 1'b1, tsd_xr: 1'b0, tsd_sw: 1'b0, rst_pin: 1'b1,
                                      spi_sel: 1'b0, wake_request_out_sel: 1'b0};

   localparam logic [7:0] ADDR_FAILSAFE_CFG = 8'h17;
   localparam logic [7:0] ADDR_RESET_CMD = 8'h19;
   localparam logic [7:0] ADDR_SWT_CFG = 8'h1c;
   localparam logic [7:0] ADDR_XCVR_CFG = 8'h1d;
   localparam logic [7:0] ADDR_INT_FLAGS = 8'h24;

   localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
   localparam logic [7:0] CMD_HARD_RESET = 8'h01;

   localparam int unsigned SWT_DIS_BIT = 7;
   localparam int unsigned SWT_SEL_MSB = 6;
   localparam int unsigned SWT_SEL_LSB = 3;
   localparam int unsigned DTO_DIS_BIT = 5;
   localparam int unsigned FAILSAFE_DISABLE_BIT_BIT = 0;
   localparam int unsigned FLAG_POWER_ON = 0;
   localparam int unsigned FLAG_THERM_XR = 1;
   localparam int unsigned FLAG_THERM_SW = 2;

   localparam logic [7:0] SWT_CFG_RST = 8'h48;
   localparam logic [7:0] XCVR_CFG_RST = 8'h00;
   localparam logic [7:0] FAILSAFE_CFG_RST = 8'h00;
   localparam logic [2:0] FLAGS_RST = 3'h1;

   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned RESET_INPUT_PULSE_US = 20;
   localparam int unsigned RESET_TOGGLE_US = 1000;
   localparam int unsigned DOMINANT_TIMEOUT_US = 20000;
   localparam int unsigned MS_US = 1000;
   localparam int unsigned RESET_INPUT_PULSE_CYC = RESET_INPUT_PULSE_US * CLK_MHZ;
   localparam int unsigned RESET_TOGGLE_CYC = RESET_TOGGLE_US * CLK_MHZ;
   localparam int unsigned DOMINANT_TIMEOUT_CYC = DOMINANT_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned MS_CYC = MS_US * CLK_MHZ;

   // Sleep/wake timeout in milliseconds, 30 s to 10 min, code 9 is 5 min
   function automatic logic [19:0] swe_ms(input logic [3:0] sel);
      logic [19:0] ms;
      ms = 20'h0;
      unique case (sel)
         4'h0: ms = 20'd30000;
         4'h1: ms = 20'd60000;
         4'h2: ms = 20'd90000;
         4'h3: ms = 20'd120000;
         4'h4: ms = 20'd150000;
         4'h5: ms = 20'd180000;
         4'h6: ms = 20'd210000;
         4'h7: ms = 20'd240000;
         4'h8: ms = 20'd270000;
         4'h9: ms = 20'd300000;
         4'ha: ms = 20'd360000;
         4'hb: ms = 20'd420000;
         4'hc: ms = 20'd480000;
         4'hd: ms = 20'd540000;
         4'he: ms = 20'd600000;
         4'hf: ms = 20'd600000;
      endcase
      return ms;
   endfunction

endpackage

// ===== rtl/sbc_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels
module sbc_sync import sbc_pkg::*; #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         meta_q <= INIT;
         q_o <= INIT;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // sbc_sync

// ===== rtl/sbc_timer.sv
// Saturating up counter with clear, run and a compare limit
module sbc_timer import sbc_pkg::*; #(
   parameter int unsigned W = 24
) (
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic clr_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   output logic done_o
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         cnt_q <= '0;
      end else if (clr_i) begin
         cnt_q <= '0;
      end else if (run_i && (cnt_q < limit_i)) begin
         cnt_q <= W'(cnt_q + 1'b1);
      end
   end

   assign done_o = (cnt_q >= limit_i);
endmodule // sbc_timer

// ===== tb/sbc_supervisor_monitor.sv
// Port checker for the protection and reset supervisor
module sbc_supervisor_monitor import sbc_pkg::*; #(
   parameter int unsigned DTO_CYC_P = 50
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire sbc_pins_t pins_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic battery_sense_out_o,
   input wire logic reset_pin_bidir_oe_o,
   input wire logic tx_enable_o,
   input wire logic regulator_en_o,
   input wire logic high_side_switch_off_o,
   input wire logic limp_on_o,
   input wire logic wake_lockout_o,
   input wire sbc_mode_t mode_o,
   input wire logic [2:0] flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic cmd_wr;
   assign cmd_wr = reg_wr_i && reg_addr_i == ADDR_RESET_CMD && pins_i.spi_sel && mode_o != M_INIT;
   a_div_mode_gate: assert property (battery_sense_out_o |-> mode_o inside {M_NORMAL, M_FAST, M_STANDBY, M_FAILSAFE}
      || $past(mode_o) inside {M_NORMAL, M_FAST, M_STANDBY, M_FAILSAFE}) else $error("divider on in wrong mode");
   a_soft_restart: assert property (cmd_wr && reg_wdata_i == CMD_SOFT_RESET |=> ##[0:1] mode_o == M_RESTART)
      else $error("soft reset missed restart");
   a_hard_init: assert property (cmd_wr && reg_wdata_i == CMD_HARD_RESET |=> ##[0:1] mode_o == M_INIT)
      else $error("hard reset missed init");
   a_standby_release: assert property ($rose(mode_o == M_STANDBY) |=> ##[0:1] !reset_pin_bidir_oe_o)
      else $error("reset pin held in standby");
   a_dto_cut: assert property ($fell(tx_enable_o) && mode_o == M_NORMAL && !pins_i.tsd_xr
      && !$past(pins_i.tsd_xr, 3) |-> !$past(pins_i.txd, DTO_CYC_P)) else $error("transmitter cut early");
   a_dto_clear: assert property ((pins_i.txd && !pins_i.tsd_xr && mode_o == M_NORMAL) [*5] |-> tx_enable_o)
      else $error("transmitter not restored");
   a_therm_act: assert property ((pins_i.tsd_xr && mode_o != M_SLEEP) [*4]
      |-> !tx_enable_o && !regulator_en_o && reset_pin_bidir_oe_o) else $error("thermal action missing");
   a_switch_follow: assert property ($stable(pins_i.tsd_sw) [*4] |-> high_side_switch_off_o == pins_i.tsd_sw)
      else $error("switch off wrong");
   a_lock_set: assert property ($rose(mode_o == M_SLEEP) && !pins_i.lin_rx && !$past(pins_i.lin_rx, 3)
      |-> ##[0:2] wake_lockout_o) else $error("lockout not set");
   a_limp_fs: assert property ((mode_o == M_FAILSAFE) [*2] |-> limp_on_o)
      else $error("limp off in fail-safe");
endmodule // sbc_supervisor_monitor

bind sbc_supervisor sbc_supervisor_monitor #(.DTO_CYC_P(DTO_CYC_P)) sbc_supervisor_monitor_i (.mclk_i, .resetn_i,
   .pins_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .battery_sense_out_o, .reset_pin_bidir_oe_o, .tx_enable_o,
   .regulator_en_o, .high_side_switch_off_o, .limp_on_o, .wake_lockout_o, .mode_o, .flags_o);

// ===== tb/sbc_host_model.sv
// Host model: register strobes, transaction pulse and reset pin pull
module sbc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic txn_o,
   output logic pull_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'hff;
      wdata_o = 8'hff;
      txn_o = 1'b0;
      pull_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
   task automatic txn();
      @(negedge clk_i);
      txn_o = 1'b1;
      @(negedge clk_i);
      txn_o = 1'b0;
   endtask
   task automatic pull(input int n);
      @(negedge clk_i);
      pull_o = 1'b1;
      repeat (n) @(negedge clk_i);
      pull_o = 1'b0;
   endtask
endmodule // sbc_host_model

// ===== tb/sbc_supervisor_tb.sv
// Testbench for the protection and reset supervisor
module sbc_supervisor_tb import sbc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TOG = 20;
   localparam int DTO = 50;
   localparam int RIN = 8;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   sbc_pins_t p = PINS_RST;
   sbc_pins_t pv;
   logic nreq = 1'b0;
   logic wr, rd, txn, pull, oe, batt, tx, rege, high_side_switch, limp, lock, inhibit_out;
   logic [7:0] addr, wdata, rdata, hrd;
   sbc_mode_t mode;
   logic [2:0] flags;
   int bad_count = 0;
   int checked = 0;
   int n;
   always #5 mclk_i = ~mclk_i;
   always_comb begin
      pv = p;
      pv.rst_pin = !(oe || pull);
   end
   sbc_supervisor #(.RST_IN_CYC_P(RIN), .TOG_CYC_P(TOG), .DTO_CYC_P(DTO), .MS_CYC_P(1)) sbc_supervisor_i (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .pins_i(pv), .spi_normal_req_i(nreq), .spi_fast_req_i(1'b0),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .spi_txn_i(txn),
      .reg_rdata_o(rdata), .battery_sense_out_o(batt), .reset_pin_bidir_o(), .reset_pin_bidir_oe_o(oe),
      .inhibit_out_o(inhibit_out), .wake_request_out_o(), .tx_enable_o(tx), .regulator_en_o(rege),
      .high_side_switch_off_o(high_side_switch), .limp_on_o(limp), .wake_lockout_o(lock), .mode_o(mode), .flags_o(flags));
   sbc_host_model sbc_host_model_i (.clk_i(mclk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata), .txn_o(txn), .pull_o(pull));
   task automatic stop_test();
      $display("checks %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic c1(input string nm, input logic s, input logic e);
      chk(nm, {7'h0, s}, {7'h0, e});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      sbc_host_model_i.rd(a, hrd);
      chk("reg", hrd, e);
   endtask
   task automatic wm(input sbc_mode_t m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         @(negedge mclk_i);
         n++;
      end
      chk("mode", {1'b0, mode}, {1'b0, m});
   endtask
   task automatic ticks(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   task automatic wake_up();
      p.wake = 1'b1;
      wm(M_STANDBY, 40);
      p.wake = 1'b0;
   endtask
   task automatic t_regs();
      rchk(ADDR_SWT_CFG, 8'h48);
      rchk(ADDR_XCVR_CFG, 8'h00);
      rchk(ADDR_FAILSAFE_CFG, 8'h00);
      rchk(ADDR_RESET_CMD, 8'h00);
      rchk(8'h30, 8'h00);
      chk("flags", {5'h0, flags}, 8'h01);
      sbc_host_model_i.txn();
      p.div_on = 1'b1;
      ticks(4);
      c1("batt", batt, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_dto();
      nreq = 1'b1;
      wm(M_NORMAL, 20);
      p.txd = 1'b0;
      ticks(DTO - 5);
      c1("tx early", tx, 1'b1);
      ticks(12);
      c1("tx cut", tx, 1'b0);
      wm(M_NORMAL, 0);
      p.txd = 1'b1;
      ticks(5);
      c1("tx back", tx, 1'b1);
      sbc_host_model_i.wr(ADDR_XCVR_CFG, 8'h20);
      p.txd = 1'b0;
      ticks(DTO + 10);
      c1("tx kept", tx, 1'b1);
      p.txd = 1'b1;
      nreq = 1'b0;
      $display("test dto done");
   endtask
   task automatic t_soft();
      sbc_host_model_i.wr(ADDR_RESET_CMD, CMD_SOFT_RESET);
      wm(M_RESTART, 3);
      @(negedge mclk_i);
      c1("oe", oe, 1'b1);
      c1("inh", inhibit_out, 1'b1);
      rchk(ADDR_XCVR_CFG, 8'h00);
      chk("flags", {5'h0, flags}, 8'h01);
      wm(M_STANDBY, TOG + 10);
      c1("tog", n + 8 > TOG, 1'b1);
      ticks(2);
      c1("oe", oe, 1'b0);
      sbc_host_model_i.txn();
      $display("test soft done");
   endtask
   task automatic t_pin();
      sbc_host_model_i.wr(ADDR_XCVR_CFG, 8'h20);
      sbc_host_model_i.pull(RIN - 4);
      ticks(6);
      wm(M_STANDBY, 0);
      sbc_host_model_i.pull(RIN + 4);
      wm(M_RESTART, 10);
      wm(M_STANDBY, TOG + 10);
      rchk(ADDR_XCVR_CFG, 8'h20);
      chk("flags", {5'h0, flags}, 8'h01);
      sbc_host_model_i.txn();
      $display("test pin done");
   endtask
   task automatic t_therm();
      p.tsd_xr = 1'b1;
      wm(M_FAILSAFE, 10);
      ticks(2);
      c1("tx", tx, 1'b0);
      c1("reg", rege, 1'b0);
      c1("oe", oe, 1'b1);
      c1("limp", limp, 1'b1);
      p.tsd_sw = 1'b1;
      ticks(5);
      c1("hss", high_side_switch, 1'b1);
      chk("flags", {5'h0, flags}, 8'h07);
      p.tsd_sw = 1'b0;
      p.tsd_xr = 1'b0;
      ticks(5);
      c1("hss", high_side_switch, 1'b0);
      sbc_host_model_i.wr(ADDR_INT_FLAGS, 8'h06);
      ticks(2);
      chk("flags", {5'h0, flags}, 8'h01);
      wake_up();
      sbc_host_model_i.wr(ADDR_FAILSAFE_CFG, 8'h01);
      p.tsd_xr = 1'b1;
      p.lin_rx = 1'b0;
      wm(M_SLEEP, 10);
      ticks(3);
      c1("lock", lock, 1'b1);
      c1("batt", batt, 1'b0);
      p.tsd_xr = 1'b0;
      p.lin_rx = 1'b1;
      ticks(5);
      c1("lock", lock, 1'b0);
      wake_up();
      sbc_host_model_i.wr(ADDR_FAILSAFE_CFG, 8'h00);
      sbc_host_model_i.txn();
      $display("test thermal done");
   endtask
   task automatic t_swe();
      sbc_host_model_i.wr(ADDR_SWT_CFG, 8'h00);
      sbc_host_model_i.pull(RIN + 4);
      wm(M_RESTART, 10);
      wm(M_STANDBY, TOG + 10);
      wm(M_FAILSAFE, 31000);
      c1("swe", n > 29000, 1'b1);
      c1("batt", batt, 1'b1);
      wm(M_SLEEP, 31000);
      sbc_host_model_i.wr(ADDR_SWT_CFG, 8'h80);
      wake_up();
      ticks(31000);
      wm(M_STANDBY, 0);
      $display("test swe done");
   endtask
   task automatic t_hard();
      sbc_host_model_i.wr(ADDR_INT_FLAGS, 8'h07);
      ticks(2);
      chk("flags", {5'h0, flags}, 8'h00);
      sbc_host_model_i.wr(ADDR_RESET_CMD, CMD_HARD_RESET);
      wm(M_INIT, 3);
      wm(M_STANDBY, 20);
      chk("flags", {5'h0, flags}, 8'h01);
      rchk(ADDR_SWT_CFG, 8'h48);
      $display("test hard done");
   endtask
   initial begin
      p.spi_sel = 1'b1;
      ticks(4);
      resetn_i = 1'b1;
      p.vcc_uv = 1'b0;
      wm(M_STANDBY, 20);
      t_regs();
      t_dto();
      t_soft();
      t_pin();
      t_therm();
      t_swe();
      t_hard();
      stop_test();
   end
   initial begin
      repeat (98000) @(posedge mclk_i);
      bad_count++;
      stop_test();
   end
endmodule // sbc_supervisor_tb
